// >>> atf_defines.svh
// Task file constants shared by the card end and the host end.
// Assumes inclusion by bare name; definitions only.
`ifndef ATF_DEFINES_SVH
`define ATF_DEFINES_SVH
`define ATF_OFF_DATA     4'h0
`define ATF_OFF_ERRFEAT  4'h1
`define ATF_OFF_SCOUNT   4'h2
`define ATF_OFF_SNUM     4'h3
`define ATF_OFF_CYLLO    4'h4
`define ATF_OFF_CYLHI    4'h5
`define ATF_OFF_DRVHD    4'h6
`define ATF_OFF_STATCMD  4'h7
`define ATF_OFF_DUP_EVEN 4'h8
`define ATF_OFF_DUP_ODD  4'h9
`define ATF_OFF_DUP_ERR  4'hD
`define ATF_OFF_ALTCTL   4'hE
`define ATF_OFF_DRVADR   4'hF
`define ATF_PRI_BASE     6'h1F
`define ATF_PRI_ALT      6'h3F
`define ATF_SEC_BASE     6'h17
`define ATF_SEC_ALT      6'h37
`define ATF_MAP_MEM      2'h0
`define ATF_MAP_CONTIG   2'h1
`define ATF_MAP_PRI      2'h2
`define ATF_MAP_SEC      2'h3
`define ATF_ST_BUSY      7
`define ATF_ST_READY     6
`define ATF_ST_WFAULT    5
`define ATF_ST_SEEK      4
`define ATF_ST_DRQ       3
`define ATF_ST_CORR      2
`define ATF_ST_ERR       0
`define ATF_ER_BBK       7
`define ATF_ER_UNC       6
`define ATF_ER_SECTOR_ID_MISSING_FLAG      4
`define ATF_ER_COMMAND_ABORTED_FLAG      2
`define ATF_ER_GEN       0
`define ATF_DH_LBA       6
`define ATF_DH_DRV       4
`define ATF_DH_FIXED     8'hA0
`define ATF_DC_NIEN      1
`define ATF_RST_SCOUNT   8'h01
`define ATF_RST_DRVHD    8'hA0
`define ATF_RST_STATUS   8'h50
`define ATF_H_ACCESS     4'h0
`define ATF_H_DATA       4'h4
`define ATF_H_STATUS     4'h8
`define ATF_H_CONFIG     4'hC
`define ATF_H_WRBIT      8
`endif

// >>> atf_pkg.sv
// Types of the task file link; the host end uses the state type.
// Assumes atf_defines.svh is on the include path.
`include "atf_defines.svh"
package atf_pkg;
	typedef enum logic [1:0] {
		ATF_MAP_MEM    = `ATF_MAP_MEM,
		ATF_MAP_CONTIG = `ATF_MAP_CONTIG,
		ATF_MAP_PRI    = `ATF_MAP_PRI,
		ATF_MAP_SEC    = `ATF_MAP_SEC
	} atf_map_e;
	typedef enum logic [3:0] {
		ATF_H_IDLE    = 4'b0001,
		ATF_H_SETUP   = 4'b0010,
		ATF_H_STROBE  = 4'b0100,
		ATF_H_RECOVER = 4'b1000
	} atf_hstate_e;
endpackage

// >>> atf_bus_if.sv
// Parallel strobe bus between host and card.
// Assumes both ends run on one clock; data wire resolved from the enables.
`timescale 1ns/1ps
`default_nettype none
interface atf_bus_if;
	logic [10:0] addr;
	logic        reg_space_n;
	logic        low_byte_card_select_n;
	logic        high_byte_card_select_n;
	logic        io_read_strobe_n;
	logic        io_write_strobe_n;
	logic [15:0] host_data;
	logic        host_data_oe;
	logic [15:0] card_data;
	logic        card_data_oe;
	logic        interrupt_request_n;
	logic [15:0] data;
	// Undriven bus reads as zero
	assign data = card_data_oe ? card_data :
		(host_data_oe ? host_data : 16'h0000);
	modport card (
		input  addr, reg_space_n, low_byte_card_select_n,
		input  high_byte_card_select_n, io_read_strobe_n,
		input  io_write_strobe_n, data,
		output card_data, card_data_oe, interrupt_request_n
	);
	modport host (
		output addr, reg_space_n, low_byte_card_select_n,
		output high_byte_card_select_n, io_read_strobe_n,
		output io_write_strobe_n, host_data, host_data_oe,
		input  data, interrupt_request_n
	);
endinterface
`default_nettype wire

// >>> atf_card.sv
// Card end: task file registers, address decode and sector data port.
// Assumes bus inputs synchronous to core_clk; a controller drives the
// user side (command completion, data words, sector stepping).
// Function
// - primary map decodes 1FH and 3FH
// - secondary map decodes 17H and 37H
// - True IDE decodes by card selects
// - 16-bit data port, word and byte
// - error valid only when not busy
// - error flag layout, unused bits zero
// - uncorrectable read sets its flag
// - missing sector ID sets its flag
// - aborted command sets its flag
// - general error sets bit 0
// - feature register write-only byte
// - sector count zero means 256
// - failed transfer leaves remaining count
// - sector count resets to 01H
// - transfers cross track and cylinder
// - host writes start sector first
// - host writes cylinder low first
// - host writes cylinder high first
// - drive/head fixed ones, LBA, drive, head
// - LBA bit selects CHS or LBA address
// - command clears bits 0,4,6, sets busy
// - status read drops interrupt, alternate not
// - configuration index picks decode map
//
// Our own choices: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module atf_card #(
	parameter int SECTORS_PER_TRACK = 32,
	parameter int HEADS             = 4
) (
	input  wire logic        core_clk,
	input  wire logic        resetn,
	atf_bus_if.card          bus,
	input  wire logic        true_ide_mode,
	input  wire logic [1:0]  config_index,
	output logic             cmd_valid,
	output logic [7:0]       cmd_code,
	output logic [7:0]       feature,
	output logic [8:0]       sector_total,
	output logic             lba_mode,
	output logic             drive_select_bit,
	output logic [27:0]      target_address,
	input  wire logic        cmd_done,
	input  wire logic        done_bad_block,
	input  wire logic        done_uncorrectable,
	input  wire logic        done_id_missing,
	input  wire logic        done_aborted,
	input  wire logic        done_general,
	input  wire logic        done_write_fault,
	input  wire logic        done_corrected,
	input  wire logic        data_request,
	input  wire logic        sector_advance,
	output logic             wr_word_valid,
	output logic [15:0]      wr_word,
	input  wire logic        rd_word_load,
	input  wire logic [15:0] rd_word,
	output logic             rd_word_taken
);
	initial begin
		if (SECTORS_PER_TRACK < 1 || SECTORS_PER_TRACK > 255 ||
			HEADS < 1 || HEADS > 16) begin
			$error("atf_card: geometry out of range");
		end
	end

	// Returns {hit, offset}; duplicates folded onto their main offsets
	function automatic logic [4:0] tf_decode(input logic ide,
		input logic [1:0] idx, input logic [10:0] a, input logic rn,
		input logic c1n, input logic c2n);
		logic [4:0] r;
		r = 5'h00;
		if (ide) begin
			if (!c1n && c2n)
				r = {2'b10, a[2:0]};
			else if (c1n && !c2n && a[2:1] == 2'b11)
				r = {2'b11, a[2:0]};
		end else if (!(c1n && c2n)) begin
			case (idx)
			`ATF_MAP_MEM: if (rn) begin
				r = a[10] ? {4'b1100, a[0]} : {1'b1, a[3:0]};
			end
			`ATF_MAP_CONTIG: if (!rn) begin
				r = {1'b1, a[3:0]};
			end
			`ATF_MAP_PRI: if (!rn && !a[3]) begin
				if (a[9:4] == `ATF_PRI_BASE)
					r = {2'b10, a[2:0]};
				else if (a[9:4] == `ATF_PRI_ALT && a[2:1] == 2'b11)
					r = {2'b11, a[2:0]};
			end
			`ATF_MAP_SEC: if (!rn && !a[3]) begin
				if (a[9:4] == `ATF_SEC_BASE)
					r = {2'b10, a[2:0]};
				else if (a[9:4] == `ATF_SEC_ALT && a[2:1] == 2'b11)
					r = {2'b11, a[2:0]};
			end
			default: r = 5'h00;
			endcase
		end
		case (r[3:0])
		`ATF_OFF_DUP_EVEN, `ATF_OFF_DUP_ODD: r[3:0] = `ATF_OFF_DATA;
		`ATF_OFF_DUP_ERR: r[3:0] = `ATF_OFF_ERRFEAT;
		4'hA, 4'hB, 4'hC: r = 5'h00;
		default: ;
		endcase
		return r;
	endfunction

	logic [4:0]  dec;
	logic [3:0]  off;
	logic        rd_prev_q, wr_prev_q, rd_start, wr_start, byte_acc;
	logic [7:0]  scount_q, snum_q, cyllo_q, cylhi_q, drvhd_q;
	logic [7:0]  feature_q, status_q, error_q, cmd_q, stat_view;
	logic        nien_q, irq_q, cmd_valid_q, byte_hi_q, rd_oe_q;
	logic [7:0]  lo_byte_q;
	logic [15:0] rd_buf_q, card_data_q, wr_word_q, rd_val;
	logic        wr_word_valid_q, rd_taken_q;
	logic [27:0] lba_next;

	assign dec = tf_decode(true_ide_mode, config_index, bus.addr,
		bus.reg_space_n, bus.low_byte_card_select_n,
		bus.high_byte_card_select_n);
	assign off      = dec[3:0];
	assign rd_start = dec[4] && !bus.io_read_strobe_n && rd_prev_q;
	assign wr_start = dec[4] && !bus.io_write_strobe_n && wr_prev_q;
	// Odd byte lane unselected means 8-bit host; IDE data is always 16
	assign byte_acc = !true_ide_mode && bus.high_byte_card_select_n;

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			rd_prev_q <= 1'b1;
			wr_prev_q <= 1'b1;
		end else begin
			rd_prev_q <= bus.io_read_strobe_n;
			wr_prev_q <= bus.io_write_strobe_n;
		end
	end

	// Bit 1 (index) always reads zero; request bit follows the controller
	always_comb begin
		stat_view = status_q;
		stat_view[`ATF_ST_DRQ] = data_request;
		stat_view[1] = 1'b0;
	end

	always_comb begin
		case (off)
		`ATF_OFF_DATA:    rd_val = byte_acc ? {8'h00, byte_hi_q ?
			rd_buf_q[15:8] : rd_buf_q[7:0]} : rd_buf_q;
		// Error content only meaningful once busy reads 0
		`ATF_OFF_ERRFEAT: rd_val = {8'h00, error_q};
		`ATF_OFF_SCOUNT:  rd_val = {8'h00, scount_q};
		`ATF_OFF_SNUM:    rd_val = {8'h00, snum_q};
		`ATF_OFF_CYLLO:   rd_val = {8'h00, cyllo_q};
		`ATF_OFF_CYLHI:   rd_val = {8'h00, cylhi_q};
		`ATF_OFF_DRVHD:   rd_val = {8'h00, drvhd_q};
		`ATF_OFF_STATCMD, `ATF_OFF_ALTCTL: rd_val = {8'h00, stat_view};
		`ATF_OFF_DRVADR:  rd_val = {8'h00, 2'b11, ~drvhd_q[3:0],
			drvhd_q[`ATF_DH_DRV], ~drvhd_q[`ATF_DH_DRV]};
		default:          rd_val = 16'h0000;
		endcase
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			card_data_q <= 16'h0000;
			rd_oe_q     <= 1'b0;
		end else begin
			if (rd_start)
				card_data_q <= rd_val;
			rd_oe_q <= rd_start || (rd_oe_q && !bus.io_read_strobe_n);
		end
	end

	// Data port byte pairing: low byte first, then high byte
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			byte_hi_q       <= 1'b0;
			lo_byte_q       <= 8'h00;
			wr_word_q       <= 16'h0000;
			wr_word_valid_q <= 1'b0;
			rd_taken_q      <= 1'b0;
		end else begin
			wr_word_valid_q <= 1'b0;
			rd_taken_q      <= 1'b0;
			if (wr_start && off == `ATF_OFF_DATA) begin
				if (!byte_acc) begin
					wr_word_q       <= bus.data;
					wr_word_valid_q <= 1'b1;
				end else if (!byte_hi_q) begin
					lo_byte_q <= bus.data[7:0];
					byte_hi_q <= 1'b1;
				end else begin
					wr_word_q       <= {bus.data[7:0], lo_byte_q};
					wr_word_valid_q <= 1'b1;
					byte_hi_q       <= 1'b0;
				end
			end
			if (rd_start && off == `ATF_OFF_DATA) begin
				rd_taken_q <= !byte_acc || byte_hi_q;
				byte_hi_q  <= byte_acc && !byte_hi_q;
			end
			if (wr_start && off == `ATF_OFF_STATCMD)
				byte_hi_q <= 1'b0;
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn)
			rd_buf_q <= 16'h0000;
		else if (rd_word_load)
			rd_buf_q <= rd_word;
	end

	// Next address for LBA stepping
	assign lba_next = {drvhd_q[3:0], cylhi_q, cyllo_q, snum_q} + 28'h0000001;

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			scount_q  <= `ATF_RST_SCOUNT;
			snum_q    <= 8'h00;
			cyllo_q   <= 8'h00;
			cylhi_q   <= 8'h00;
			drvhd_q   <= `ATF_RST_DRVHD;
			feature_q <= 8'h00;
			nien_q    <= 1'b0;
		end else begin
			if (sector_advance) begin
				// Remaining count left in place if the command fails
				scount_q <= scount_q - 8'h01;
				if (drvhd_q[`ATF_DH_LBA]) begin
					{cylhi_q, cyllo_q, snum_q} <= lba_next[23:0];
					drvhd_q[3:0] <= lba_next[27:24];
				end else if (snum_q >= 8'(SECTORS_PER_TRACK)) begin
					snum_q <= 8'h01;
					if (drvhd_q[3:0] == 4'(HEADS - 1)) begin
						drvhd_q[3:0] <= 4'h0;
						{cylhi_q, cyllo_q} <= {cylhi_q, cyllo_q} + 16'h0001;
					end else begin
						drvhd_q[3:0] <= drvhd_q[3:0] + 4'h1;
					end
				end else begin
					snum_q <= snum_q + 8'h01;
				end
			end
			if (wr_start) begin
				case (off)
				`ATF_OFF_ERRFEAT: feature_q <= bus.data[7:0];
				`ATF_OFF_SCOUNT:  scount_q  <= bus.data[7:0];
				`ATF_OFF_SNUM:    snum_q    <= bus.data[7:0];
				`ATF_OFF_CYLLO:   cyllo_q   <= bus.data[7:0];
				`ATF_OFF_CYLHI:   cylhi_q   <= bus.data[7:0];
				`ATF_OFF_DRVHD:
					drvhd_q <= bus.data[7:0] | `ATF_DH_FIXED;
				`ATF_OFF_ALTCTL:  nien_q <= bus.data[`ATF_DC_NIEN];
				// Drive address is read-only: write dropped
				`ATF_OFF_DRVADR:  ;
				default: ;
				endcase
			end
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			cmd_q       <= 8'h00;
			cmd_valid_q <= 1'b0;
		end else begin
			cmd_valid_q <= wr_start && off == `ATF_OFF_STATCMD;
			if (wr_start && off == `ATF_OFF_STATCMD)
				cmd_q <= bus.data[7:0];
		end
	end

	// Command write wins over a completion landing in the same cycle
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			status_q <= `ATF_RST_STATUS;
		end else if (wr_start && off == `ATF_OFF_STATCMD) begin
			status_q[`ATF_ST_ERR]   <= 1'b0;
			status_q[`ATF_ST_SEEK]  <= 1'b0;
			status_q[`ATF_ST_READY] <= 1'b0;
			status_q[`ATF_ST_BUSY]  <= 1'b1;
		end else if (cmd_done) begin
			status_q[`ATF_ST_BUSY]   <= 1'b0;
			status_q[`ATF_ST_READY]  <= 1'b1;
			status_q[`ATF_ST_SEEK]   <= 1'b1;
			status_q[`ATF_ST_WFAULT] <= done_write_fault;
			status_q[`ATF_ST_CORR]   <= done_corrected;
			status_q[`ATF_ST_ERR]    <= done_bad_block || done_general ||
				done_uncorrectable || done_id_missing || done_aborted;
		end
	end

	// Flags of the last command; unused bits 5, 3, 1 stay zero
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			error_q <= 8'h00;
		end else begin
			if (wr_start && off == `ATF_OFF_STATCMD)
				error_q <= 8'h00;
			if (cmd_done) begin
				error_q[`ATF_ER_BBK]  <= done_bad_block;
				error_q[`ATF_ER_UNC]  <= done_uncorrectable;
				error_q[`ATF_ER_SECTOR_ID_MISSING_FLAG] <= done_id_missing;
				error_q[`ATF_ER_COMMAND_ABORTED_FLAG] <= done_aborted;
				error_q[`ATF_ER_GEN]  <= done_general;
			end
		end
	end

	// Set wins over the clearing status read
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn)
			irq_q <= 1'b0;
		else if (cmd_done && !nien_q)
			irq_q <= 1'b1;
		else if (rd_start && off == `ATF_OFF_STATCMD)
			irq_q <= 1'b0;
	end

	assign bus.card_data           = card_data_q;
	assign bus.card_data_oe        = rd_oe_q && !bus.io_read_strobe_n;
	assign bus.interrupt_request_n = !irq_q;
	assign cmd_valid        = cmd_valid_q;
	assign cmd_code         = cmd_q;
	assign feature          = feature_q;
	assign sector_total     = (scount_q == 8'h00) ? 9'h100 :
		{1'b0, scount_q};
	assign lba_mode         = drvhd_q[`ATF_DH_LBA];
	assign drive_select_bit = drvhd_q[`ATF_DH_DRV];
	assign target_address   = {drvhd_q[3:0], cylhi_q, cyllo_q, snum_q};
	assign wr_word_valid    = wr_word_valid_q;
	assign wr_word          = wr_word_q;
	assign rd_word_taken    = rd_taken_q;
endmodule
`default_nettype wire

// >>> atf_host.sv
// Host end: runs one task file access per software order.
// Assumes an Avalon-MM master on the software side, one clock.
`timescale 1ns/1ps
`default_nettype none
module atf_host #(
	parameter int STROBE_CYCLES = 4
) (
	input  wire logic        core_clk,
	input  wire logic        resetn,
	atf_bus_if.host          bus,
	input  wire logic [3:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	output logic [31:0]      avs_readdata,
	output logic             avs_waitrequest
);
	initial begin
		if (STROBE_CYCLES < 2 || STROBE_CYCLES > 255)
			$error("atf_host: STROBE_CYCLES out of range");
	end

	// Returns {reg_space_n, high select_n, low select_n, addr}
	function automatic logic [13:0] host_map(input logic [3:0] o,
		input logic [1:0] idx, input logic ide, input logic bytew);
		logic [13:0] r;
		r = {1'b0, bytew, 1'b0, 7'h00, o};
		if (ide)
			r = {1'b0, !o[3], o[3], 8'h00, o[2:0]};
		else case (idx)
		`ATF_MAP_MEM: r[13] = 1'b1;
		`ATF_MAP_PRI: r[10:0] = {1'b0, o[3] ? `ATF_PRI_ALT :
			`ATF_PRI_BASE, 1'b0, o[2:0]};
		`ATF_MAP_SEC: r[10:0] = {1'b0, o[3] ? `ATF_SEC_ALT :
			`ATF_SEC_BASE, 1'b0, o[2:0]};
		default: ;
		endcase
		return r;
	endfunction

	atf_pkg::atf_hstate_e state_q;
	logic [7:0]  cnt_q;
	logic [3:0]  config_q, off_q;
	logic        is_wr_q, ack_q, stall, start, err_valid_q;
	logic [15:0] wdata_q, rdata_q;
	logic [31:0] readdata_q;
	logic [13:0] map_q;

	assign stall = avs_write && avs_address == `ATF_H_ACCESS &&
		state_q != atf_pkg::ATF_H_IDLE;
	assign start = avs_write && ack_q && avs_address == `ATF_H_ACCESS;
	assign avs_waitrequest = (avs_read || avs_write) && !ack_q;
	assign avs_readdata    = readdata_q;

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			ack_q      <= 1'b0;
			readdata_q <= 32'h00000000;
		end else begin
			ack_q <= (avs_read || avs_write) && !ack_q && !stall;
			if (avs_read && !ack_q) begin
				case (avs_address)
				`ATF_H_DATA:   readdata_q <= {16'h0000, rdata_q};
				`ATF_H_STATUS: readdata_q <= {29'h00000000, err_valid_q,
					!bus.interrupt_request_n,
					state_q != atf_pkg::ATF_H_IDLE};
				`ATF_H_CONFIG: readdata_q <= {28'h0000000, config_q};
				default:       readdata_q <= 32'h00000000;
				endcase
			end
		end
	end

	// Software must load sector number and cylinder before the command
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			config_q <= 4'h0;
			wdata_q  <= 16'h0000;
		end else if (avs_write && ack_q) begin
			if (avs_address == `ATF_H_CONFIG)
				config_q <= avs_writedata[3:0];
			if (avs_address == `ATF_H_DATA)
				wdata_q <= avs_writedata[15:0];
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			state_q     <= atf_pkg::ATF_H_IDLE;
			cnt_q       <= 8'h00;
			off_q       <= 4'h0;
			is_wr_q     <= 1'b0;
			map_q       <= 14'h3800;
			rdata_q     <= 16'h0000;
			err_valid_q <= 1'b0;
		end else begin
			case (state_q)
			atf_pkg::ATF_H_IDLE: if (start) begin
				off_q   <= avs_writedata[3:0];
				is_wr_q <= avs_writedata[`ATF_H_WRBIT];
				map_q   <= host_map(avs_writedata[3:0], config_q[1:0],
					config_q[2], config_q[3]);
				state_q <= atf_pkg::ATF_H_SETUP;
			end
			atf_pkg::ATF_H_SETUP: begin
				cnt_q   <= 8'(STROBE_CYCLES - 1);
				state_q <= atf_pkg::ATF_H_STROBE;
			end
			atf_pkg::ATF_H_STROBE: begin
				cnt_q <= cnt_q - 8'h01;
				if (cnt_q == 8'h00) begin
					if (!is_wr_q) begin
						rdata_q <= bus.data;
						// Error contents trusted only after a not-busy status
						if (off_q == `ATF_OFF_STATCMD ||
							off_q == `ATF_OFF_ALTCTL)
							err_valid_q <= !bus.data[`ATF_ST_BUSY];
					end else if (off_q == `ATF_OFF_STATCMD) begin
						err_valid_q <= 1'b0;
					end
					state_q <= atf_pkg::ATF_H_RECOVER;
				end
			end
			atf_pkg::ATF_H_RECOVER: begin
				map_q   <= 14'h3800;
				state_q <= atf_pkg::ATF_H_IDLE;
			end
			default: state_q <= atf_pkg::ATF_H_IDLE;
			endcase
		end
	end

	// Sector number and cylinder writes are plain offsets 3..5
	assign bus.addr                    = map_q[10:0];
	assign bus.reg_space_n             = map_q[13];
	assign bus.high_byte_card_select_n = map_q[12];
	assign bus.low_byte_card_select_n  = map_q[11];
	assign bus.io_read_strobe_n  = !(state_q == atf_pkg::ATF_H_STROBE &&
		!is_wr_q);
	assign bus.io_write_strobe_n = !(state_q == atf_pkg::ATF_H_STROBE &&
		is_wr_q);
	assign bus.host_data    = wdata_q;
	assign bus.host_data_oe = is_wr_q && state_q != atf_pkg::ATF_H_IDLE;
endmodule
`default_nettype wire

// >>> atf_bus_asserts.sv
// Wire checks on the strobe bus joining host and card ends.
// Assumes one clock; takes the interface's signals as plain inputs.
`timescale 1ns/1ps
`default_nettype none
module atf_bus_asserts #(
	parameter int STROBE_CYCLES = 4
) (
	input  wire logic        core_clk,
	input  wire logic        resetn,
	input  wire logic [10:0] addr,
	input  wire logic        low_byte_card_select_n,
	input  wire logic        io_read_strobe_n,
	input  wire logic        io_write_strobe_n,
	input  wire logic        host_data_oe,
	input  wire logic        card_data_oe,
	input  wire logic        interrupt_request_n
);
	logic       strobe;
	logic       stat_rd;
	logic [7:0] low_q;
	assign strobe = !io_read_strobe_n || !io_write_strobe_n;
	// Primary or secondary status location, never the alternate one
	assign stat_rd = addr[2:0] == 3'h7 && !low_byte_card_select_n &&
		(addr[9:4] == 6'h1F || addr[9:4] == 6'h17);
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn)
			low_q <= 8'h00;
		else if (!io_write_strobe_n)
			low_q <= low_q + 8'h01;
		else
			low_q <= 8'h00;
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (!resetn);
	a_no_contention: assert property (!(card_data_oe && host_data_oe))
		else $error("both ends drive the data bus");
	a_strobes_apart: assert property (io_read_strobe_n || io_write_strobe_n)
		else $error("read and write strobes low together");
	a_card_drive_read: assert property ($fell(io_read_strobe_n) && stat_rd
		|=> card_data_oe) else $error("card silent on a status read");
	a_host_oe_write: assert property (host_data_oe |-> io_read_strobe_n)
		else $error("host drives data during a read");
	a_addr_held: assert property (strobe && $past(strobe) |-> $stable(addr))
		else $error("address moved under a strobe");
	a_strobe_width: assert property ($rose(io_write_strobe_n) |->
		low_q == STROBE_CYCLES) else $error("write strobe width wrong");
	a_status_clears: assert property ($fell(io_read_strobe_n) && stat_rd
		|-> ##[1:3] interrupt_request_n) else $error("status read kept irq");
	a_alt_keeps_irq: assert property ($fell(io_read_strobe_n) &&
		addr[2:0] == 3'h6 && !interrupt_request_n |-> !interrupt_request_n [*4])
		else $error("alternate read dropped irq");
	c_status_clear: cover property ($fell(io_read_strobe_n) && stat_rd &&
		!interrupt_request_n);
	c_write: cover property ($rose(io_write_strobe_n));
	c_card_read: cover property (card_data_oe);
endmodule
`default_nettype wire

// >>> ata_task_file_registers_bench.sv
// Self-checking bench: host end and card end joined over the bus.
// Assumes the design files; software side speaks Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
module ata_task_file_registers_bench;
	logic        core_clk = 1'b0;
	logic        resetn, avs_read, avs_write, avs_waitrequest, irq_n;
	logic        true_ide_mode, cmd_valid, lba_mode, cmd_done;
	logic        data_request, sector_advance, rd_word_load;
	logic        wr_word_valid, rd_word_taken, drv;
	logic [3:0]  avs_address;
	logic [31:0] avs_writedata, avs_readdata, q;
	logic [1:0]  config_index;
	logic [7:0]  cmd_code, feature, last_cmd;
	logic [8:0]  sector_total;
	logic [27:0] target_address;
	logic [4:0]  done_f;
	logic [15:0] wr_word, rd_word, last_wr;
	int          fail_count = 0;
	int          total_checks = 0;
	int          taken = 0;
	// Offset, value written, value read back
	logic [23:0] rows [7] = '{24'h020000, 24'h03A5A5, 24'h043C3C,
		24'h05C3C3, 24'h061BBB, 24'h017700, 24'h0FFFD2};
	always #2.5 core_clk = ~core_clk;
	atf_bus_if atf_bus_if_i ();
	assign irq_n = atf_bus_if_i.interrupt_request_n;
	atf_host #(.STROBE_CYCLES(4)) atf_host_i (.core_clk(core_clk),
		.resetn(resetn), .bus(atf_bus_if_i), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest));
	atf_card atf_card_i (.core_clk(core_clk), .resetn(resetn),
		.bus(atf_bus_if_i), .true_ide_mode(true_ide_mode),
		.config_index(config_index), .cmd_valid(cmd_valid),
		.cmd_code(cmd_code), .feature(feature),
		.sector_total(sector_total), .lba_mode(lba_mode),
		.drive_select_bit(drv), .target_address(target_address),
		.cmd_done(cmd_done), .done_bad_block(done_f[4]),
		.done_uncorrectable(done_f[3]), .done_id_missing(done_f[2]),
		.done_aborted(done_f[1]), .done_general(done_f[0]),
		.done_write_fault(1'b0), .done_corrected(1'b0),
		.data_request(data_request), .sector_advance(sector_advance),
		.wr_word_valid(wr_word_valid), .wr_word(wr_word),
		.rd_word_load(rd_word_load), .rd_word(rd_word),
		.rd_word_taken(rd_word_taken));
	atf_bus_asserts #(.STROBE_CYCLES(4)) atf_bus_asserts_i (
		.core_clk(core_clk), .resetn(resetn), .addr(atf_bus_if_i.addr),
		.low_byte_card_select_n(atf_bus_if_i.low_byte_card_select_n),
		.io_read_strobe_n(atf_bus_if_i.io_read_strobe_n),
		.io_write_strobe_n(atf_bus_if_i.io_write_strobe_n),
		.host_data_oe(atf_bus_if_i.host_data_oe),
		.card_data_oe(atf_bus_if_i.card_data_oe),
		.interrupt_request_n(irq_n));
	// Pulses are one cycle wide, so latch them for later comparison
	always @(posedge core_clk) begin
		if (wr_word_valid === 1'b1)
			last_wr <= wr_word;
		if (cmd_valid === 1'b1)
			last_cmd <= cmd_code;
		if (rd_word_taken === 1'b1)
			taken <= taken + 1;
	end
	task automatic summarize;
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic chk_out(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
		chk_out({24'h0, got}, {24'h0, exp});
	endtask
	task automatic av(input logic w, input logic [3:0] a, input logic [31:0] d);
		int n;
		n = 0;
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= w;
		avs_read <= !w;
		// Pre-edge values: what the slave sampled at this edge
		do begin
			@(posedge core_clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 100);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge core_clk);
		if (n >= 100) begin
			fail_count++;
			summarize();
		end
	endtask
	task automatic tf(input logic w, input logic [3:0] off, input logic [15:0] v);
		int n;
		n = 0;
		if (w)
			av(1'b1, 4'h4, {16'h0, v});
		av(1'b1, 4'h0, {23'h0, w, 4'h0, off});
		do begin
			av(1'b0, 4'h8, 32'h0);
			n++;
		end while (q[0] !== 1'b0 && n < 50);
		if (n >= 50) begin
			fail_count++;
			summarize();
		end
		if (!w)
			av(1'b0, 4'h4, 32'h0);
	endtask
	task automatic cfg(input logic [1:0] m, input logic ide, input logic bw);
		config_index <= m;
		true_ide_mode <= ide;
		av(1'b1, 4'hC, {28'h0, bw, ide, m});
	endtask
	task automatic done(input logic [4:0] f);
		done_f <= f;
		cmd_done <= 1'b1;
		@(posedge core_clk);
		cmd_done <= 1'b0;
		@(posedge core_clk);
	endtask
	initial begin
		resetn = 1'b0;
		avs_address = 4'h0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		true_ide_mode = 1'b0;
		config_index = 2'h2;
		cmd_done = 1'b0;
		done_f = 5'h00;
		data_request = 1'b0;
		sector_advance = 1'b0;
		rd_word_load = 1'b0;
		rd_word = 16'h0000;
		repeat (8) @(posedge core_clk);
		resetn <= 1'b1;
		@(posedge core_clk);
		chk_out({31'h0, irq_n}, 32'h1);
		cfg(2'h2, 1'b0, 1'b0);
		tf(1'b0, 4'h2, 16'h0);
		chk_reg(q[7:0], 8'h01);
		tf(1'b0, 4'h6, 16'h0);
		chk_reg(q[7:0], 8'hA0);
		foreach (rows[i]) begin
			tf(1'b1, rows[i][19:16], {8'h0, rows[i][15:8]});
			tf(1'b0, rows[i][19:16], 16'h0);
			chk_reg(q[7:0], rows[i][7:0]);
		end
		chk_out({24'h0, feature}, 32'h77);
		chk_out({23'h0, sector_total}, 32'h100);
		chk_out({31'h0, drv}, 32'h1);
		tf(1'b0, 4'h6, 16'h0);
		chk_reg(q[7:0], 8'hBB);
		for (int i = 0; i < 3; i++) begin
			cfg(i == 1 ? 2'h3 : 2'h2, i == 2, 1'b0);
			tf(1'b1, 4'h3, {8'h0, 8'h10 + i[7:0]});
			tf(1'b0, 4'h3, 16'h0);
			chk_reg(q[7:0], 8'h10 + i[7:0]);
			tf(1'b0, 4'hF, 16'h0);
			chk_reg(q[7:0], 8'hD2);
		end
		// Host aims at the primary map while the card decodes secondary
		cfg(2'h2, 1'b0, 1'b0);
		config_index <= 2'h3;
		tf(1'b1, 4'h3, 16'h00EE);
		config_index <= 2'h2;
		tf(1'b0, 4'h3, 16'h0);
		chk_reg(q[7:0], 8'h12);
		tf(1'b1, 4'h6, 16'h00E0);
		tf(1'b1, 4'h5, 16'h0);
		tf(1'b1, 4'h4, 16'h0);
		tf(1'b1, 4'h3, 16'h00FF);
		tf(1'b1, 4'h2, 16'h0003);
		chk_out({31'h0, lba_mode}, 32'h1);
		chk_out({4'h0, target_address}, 32'hFF);
		sector_advance <= 1'b1;
		@(posedge core_clk);
		sector_advance <= 1'b0;
		@(posedge core_clk);
		chk_out({4'h0, target_address}, 32'h100);
		tf(1'b0, 4'h2, 16'h0);
		chk_reg(q[7:0], 8'h02);
		for (int i = 0; i < 5; i++) begin
			tf(1'b1, 4'h7, 16'h0020);
			chk_reg(last_cmd, 8'h20);
			tf(1'b0, 4'hE, 16'h0);
			chk_reg(q[7:0] & 8'hD1, 8'h80);
			done(5'h01 << i);
			tf(1'b0, 4'h1, 16'h0);
			chk_reg(q[7:0], i == 4 ? 8'h80 :
				8'h01 << (2 * i));
			chk_out({31'h0, irq_n}, 32'h0);
			tf(1'b0, 4'hE, 16'h0);
			chk_out({31'h0, irq_n}, 32'h0);
			tf(1'b0, 4'h7, 16'h0);
			chk_reg(q[7:0] & 8'h81, 8'h01);
			chk_out({31'h0, irq_n}, 32'h1);
			av(1'b0, 4'h8, 32'h0);
			chk_out(q, 32'h4);
		end
		data_request <= 1'b1;
		tf(1'b1, 4'h0, 16'h1234);
		chk_out({16'h0, last_wr}, 32'h1234);
		rd_word <= 16'hBEEF;
		rd_word_load <= 1'b1;
		@(posedge core_clk);
		rd_word_load <= 1'b0;
		@(posedge core_clk);
		tf(1'b0, 4'h0, 16'h0);
		chk_out({16'h0, q[15:0]}, 32'hBEEF);
		chk_out(taken, 32'h1);
		cfg(2'h2, 1'b0, 1'b1);
		tf(1'b1, 4'h0, 16'h0078);
		tf(1'b1, 4'h0, 16'h0056);
		chk_out({16'h0, last_wr}, 32'h5678);
		summarize();
	end
endmodule
`default_nettype wire
